// File: verilog/lcc_cfg.svh
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH

`define LCC_NUM_CELLS   10
`define LCC_NUM_CTRL    10
`define LCC_NUM_ROW     8
`define LCC_NUM_ROUTE   8
`define LCC_NUM_SRC     38
`define LCC_SEL_W       6
`define LCC_CSEL_W      4
`define LCC_CSEL_BITS   40
`define LCC_ADDR_W      8

`define LCC_OFS_CSEL_LO 8'h00
`define LCC_OFS_CSEL_HI 8'h04
`define LCC_OFS_STATUS  8'h08
`define LCC_PAGE_MASK   2'h1
`define LCC_PAGE_CFG    2'h2

`define LCC_CFG_USE_REG 24
`define LCC_CFG_CLK_SEL 25
`define LCC_CFG_CLR_SEL 26
`define LCC_CFG_LUT_CH  27
`define LCC_CFG_REG_CH  28
`define LCC_CFG_ARITH   29
`define LCC_CFG_WMASK   32'h3fffffff

`define LCC_STAT_REG_LSB 16
`define LCC_STAT_CARRY   28

`define LCC_RST_WORD    32'h00000000
`define LCC_RST_MASK    16'h0000
`define LCC_RST_HI      8'h00

`endif

// File: verilog/lcc_pkg.sv
package lcc_pkg;

  typedef logic [31:0] lcc_word_t;
  typedef logic [15:0] lcc_mask_t;

  // position in this list is the control signal's index
  typedef enum logic [3:0]
  {
    LCC_CTL_CLK1,
    LCC_CTL_CLK2,
    LCC_CTL_ENA1,
    LCC_CTL_ENA2,
    LCC_CTL_ACLR0,
    LCC_CTL_ACLR1,
    LCC_CTL_SCLR,
    LCC_CTL_ALOAD,
    LCC_CTL_SLOAD,
    LCC_CTL_ADDSUB
  } lcc_ctl_t;

endpackage

// File: verilog/lcc_logic_cell.sv
`timescale 1ns/1ps
module lcc_logic_cell
(
  input  wire logic                ref_clk_i,
  input  wire logic                reset_n_i,
  input  wire lcc_pkg::lcc_mask_t  lut_mask_i,
  input  wire logic [3:0]          data_i,
  input  wire logic                use_reg_i,
  input  wire logic                clk_sel_i,
  input  wire logic                clr_sel_i,
  input  wire logic                lut_chain_en_i,
  input  wire logic                reg_chain_en_i,
  input  wire logic                arith_i,
  input  wire logic                lut_chain_i,
  input  wire logic                reg_chain_i,
  input  wire logic                carry_i,
  input  wire logic                clk1_tick_i,
  input  wire logic                clk2_tick_i,
  input  wire logic                aclr0_i,
  input  wire logic                aclr1_i,
  input  wire logic                aload_i,
  input  wire logic                sclr_i,
  input  wire logic                sload_i,
  input  wire logic                addsub_i,
  output logic                     lut_o,
  output logic                     reg_o,
  output logic                     carry_o,
  output logic                     out_o
);

  logic       reg_q;
  logic       reg_d;
  logic [3:0] in_w;
  logic       b_w;
  logic       tick_w;
  logic       aclr_w;

  always_comb
  begin
    in_w = data_i;
    if (lut_chain_en_i)
    begin
      in_w[0] = lut_chain_i;
    end
    b_w = in_w[1] ^ addsub_i;
    if (arith_i)
    begin
      lut_o   = in_w[0] ^ b_w ^ carry_i;
      carry_o = (in_w[0] & b_w) | (carry_i & (in_w[0] ^ b_w));
    end
    else
    begin
      lut_o   = lut_mask_i[in_w];
      carry_o = carry_i;
    end
    tick_w = clk_sel_i ? clk2_tick_i : clk1_tick_i;
    aclr_w = clr_sel_i ? aclr1_i : aclr0_i;
    reg_d  = reg_q;
    // asynchronous clears and load act without waiting for a cluster clock tick
    if (aclr_w)
    begin
      reg_d = 1'b0;
    end
    else if (aload_i)
    begin
      reg_d = in_w[3];
    end
    else if (tick_w)
    begin
      if (sclr_i)
      begin
        reg_d = 1'b0;
      end
      else if (sload_i)
      begin
        reg_d = in_w[3];
      end
      else
      begin
        reg_d = reg_chain_en_i ? reg_chain_i : lut_o;
      end
    end
    reg_o = reg_q;
    out_o = use_reg_i ? reg_q : lut_o;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      reg_q <= 1'b0;
    end
    else
    begin
      reg_q <= reg_d;
    end
  end

endmodule // lcc_logic_cell

// File: verilog/lcc_ctrl_gen.sv
`timescale 1ns/1ps
`include "lcc_cfg.svh"
module lcc_ctrl_gen
(
  input  wire logic                       ref_clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic [`LCC_NUM_ROW-1:0]    row_clk_i,
  input  wire logic [`LCC_NUM_ROUTE-1:0]  route_i,
  input  wire logic [`LCC_CSEL_BITS-1:0]  csel_i,
  output logic      [`LCC_NUM_CTRL-1:0]   ctl_o,
  output logic                            clk1_tick_o,
  output logic                            clk2_tick_o
);

  logic [15:0] src_w;
  logic [1:0]  prev_q;
  logic [1:0]  prev_d;

  assign src_w = {route_i, row_clk_i};

  genvar k;
  generate
    for (k = 0; k < `LCC_NUM_CTRL; k = k + 1)
    begin : g_ctl
      assign ctl_o[k] = src_w[csel_i[k*`LCC_CSEL_W +: `LCC_CSEL_W]];
    end
  endgenerate

  always_comb
  begin
    prev_d = {ctl_o[lcc_pkg::LCC_CTL_CLK2], ctl_o[lcc_pkg::LCC_CTL_CLK1]};
    // clock one ticks on rising edges, clock two on falling edges
    clk1_tick_o = ctl_o[lcc_pkg::LCC_CTL_CLK1] & ~prev_q[0]
                & ctl_o[lcc_pkg::LCC_CTL_ENA1];
    clk2_tick_o = ~ctl_o[lcc_pkg::LCC_CTL_CLK2] & prev_q[1]
                & ctl_o[lcc_pkg::LCC_CTL_ENA2];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      prev_q <= 2'h0;
    end
    else
    begin
      prev_q <= prev_d;
    end
  end

endmodule // lcc_ctrl_gen

// File: verilog/lcc_logic_cluster.sv
// Summary of operation
// - The cluster holds exactly ten logic cells with chains and controls.
// - Cell inputs come from routing, own cell outputs and left/right links.
// - Local plus left and right links let one cell reach thirty others.
// - A cell may take the previous cell's lookup output as its first input.
// - A register may load the previous cell's register, forming a shifter.
// - Ten cluster control signals exist: two clocks, two enables and six more.
// - Each cell's clock choice also picks the matching clock enable.
// - Clock one acts on rising edges and clock two on falling edges.
// - A low clock enable stops its clock so registers hold.
// - Two asynchronous clears and one asynchronous load serve the cells.
// - Asynchronous load with its data input high presets the register.
// - A cluster add/subtract select makes each arithmetic-mode cell add or subtract.
// - Control signals are picked from eight row clocks and local routing.
// - Synchronous clear and load work for any mapped function.
// - Subtraction inverts the second operand and forces first carry to one.
// - Synchronous clear and load reach every cell register at the tick of its selected clock.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "lcc_cfg.svh"
module lcc_logic_cluster
(
  input  wire logic                        ref_clk_i,
  input  wire logic                        reset_n_i,
  input  wire logic [`LCC_ADDR_W-1:0]      avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [31:0]                 avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [31:0]                 avs_readdata_o,
  output logic                             avs_waitrequest_o,
  input  wire logic [`LCC_NUM_ROW-1:0]     row_clk_i,
  input  wire logic [`LCC_NUM_ROUTE-1:0]   route_i,
  input  wire logic [`LCC_NUM_CELLS-1:0]   direct_left_i,
  input  wire logic [`LCC_NUM_CELLS-1:0]   direct_right_i,
  input  wire logic                        carry_in_i,
  input  wire logic                        reg_chain_in_i,
  output logic      [`LCC_NUM_CELLS-1:0]   cell_out_o,
  output logic                             carry_out_o,
  output logic                             reg_chain_out_o
);

  localparam int NC = `LCC_NUM_CELLS;

  // bus slave state
  logic                wait_q;
  logic                wait_d;
  lcc_pkg::lcc_word_t  rdata_q;
  lcc_pkg::lcc_word_t  rdata_d;
  lcc_pkg::lcc_word_t  rd_w;

  // configuration state
  lcc_pkg::lcc_word_t  csel_lo_q;
  lcc_pkg::lcc_word_t  csel_lo_d;
  logic [7:0]          csel_hi_q;
  logic [7:0]          csel_hi_d;
  lcc_pkg::lcc_mask_t  mask_q [NC];
  lcc_pkg::lcc_mask_t  mask_d [NC];
  lcc_pkg::lcc_word_t  cfg_q  [NC];
  lcc_pkg::lcc_word_t  cfg_d  [NC];

  // cluster output state
  logic [NC-1:0]       out_q;
  logic [NC-1:0]       out_d;
  logic                carry_q;
  logic                carry_d;
  logic                chain_q;
  logic                chain_d;

  // cell and control wiring
  logic [`LCC_NUM_SRC-1:0]  src_w;
  logic [`LCC_NUM_CTRL-1:0] ctl_w;
  logic                     clk1_tick_w;
  logic                     clk2_tick_w;
  logic [NC-1:0]            lut_w;
  logic [NC-1:0]            reg_w;
  logic [NC-1:0]            carry_w;
  logic [NC-1:0]            cout_w;
  logic                     commit_w;
  logic [3:0]               idx_w;
  logic                     idx_ok_w;
  logic [1:0]               page_w;

  function automatic lcc_pkg::lcc_word_t merge_be
  (
    input lcc_pkg::lcc_word_t old_v,
    input lcc_pkg::lcc_word_t new_v,
    input logic [3:0]         be
  );
    lcc_pkg::lcc_word_t r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // feedback uses the registered copy so no combinational loop can form
  assign src_w = {direct_right_i, direct_left_i, out_q, route_i};

  assign page_w   = avs_address_i[7:6];
  assign idx_w    = avs_address_i[5:2];
  assign idx_ok_w = (idx_w < 4'(NC));
  assign commit_w = avs_write_i & ~wait_q;

  lcc_ctrl_gen u_ctrl
  (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .row_clk_i   (row_clk_i),
    .route_i     (route_i),
    .csel_i      ({csel_hi_q, csel_lo_q}),
    .ctl_o       (ctl_w),
    .clk1_tick_o (clk1_tick_w),
    .clk2_tick_o (clk2_tick_w)
  );

  genvar i;
  generate
    for (i = 0; i < NC; i = i + 1)
    begin : g_cell
      logic [3:0] data_w;
      logic       lch_w;
      logic       rch_w;

      always_comb
      begin
        for (int k = 0; k < 4; k++)
        begin
          logic [`LCC_SEL_W-1:0] s;
          s = cfg_q[i][k*`LCC_SEL_W +: `LCC_SEL_W];
          data_w[k] = (s < 6'(`LCC_NUM_SRC)) ? src_w[s] : 1'b0;
        end
      end

      if (i == 0)
      begin : g_first
        // subtraction forces the carry into the first cell high
        assign carry_w[i] = ctl_w[lcc_pkg::LCC_CTL_ADDSUB]
                          | carry_in_i;
        assign lch_w      = 1'b0;
        assign rch_w      = reg_chain_in_i;
      end
      else
      begin : g_next
        assign carry_w[i] = cout_w[i-1];
        assign lch_w      = lut_w[i-1];
        assign rch_w      = reg_w[i-1];
      end

      // shared control lines reach every cell in the same cycle
      lcc_logic_cell u_cell
      (
        .ref_clk_i      (ref_clk_i),
        .reset_n_i      (reset_n_i),
        .lut_mask_i     (mask_q[i]),
        .data_i         (data_w),
        .use_reg_i      (cfg_q[i][`LCC_CFG_USE_REG]),
        .clk_sel_i      (cfg_q[i][`LCC_CFG_CLK_SEL]),
        .clr_sel_i      (cfg_q[i][`LCC_CFG_CLR_SEL]),
        .lut_chain_en_i (cfg_q[i][`LCC_CFG_LUT_CH]),
        .reg_chain_en_i (cfg_q[i][`LCC_CFG_REG_CH]),
        .arith_i        (cfg_q[i][`LCC_CFG_ARITH]),
        .lut_chain_i    (lch_w),
        .reg_chain_i    (rch_w),
        .carry_i        (carry_w[i]),
        .clk1_tick_i    (clk1_tick_w),
        .clk2_tick_i    (clk2_tick_w),
        .aclr0_i        (ctl_w[lcc_pkg::LCC_CTL_ACLR0]),
        .aclr1_i        (ctl_w[lcc_pkg::LCC_CTL_ACLR1]),
        .aload_i        (ctl_w[lcc_pkg::LCC_CTL_ALOAD]),
        .sclr_i         (ctl_w[lcc_pkg::LCC_CTL_SCLR]),
        .sload_i        (ctl_w[lcc_pkg::LCC_CTL_SLOAD]),
        .addsub_i       (ctl_w[lcc_pkg::LCC_CTL_ADDSUB]),
        .lut_o          (lut_w[i]),
        .reg_o          (reg_w[i]),
        .carry_o        (cout_w[i]),
        .out_o          (out_d[i])
      );
    end
  endgenerate

  // read mux
  always_comb
  begin
    rd_w = `LCC_RST_WORD;
    if (page_w == `LCC_PAGE_MASK && idx_ok_w)
    begin
      rd_w = {16'h0000, mask_q[idx_w]};
    end
    else if (page_w == `LCC_PAGE_CFG && idx_ok_w)
    begin
      rd_w = cfg_q[idx_w];
    end
    else
    begin
      case (avs_address_i)
        `LCC_OFS_CSEL_LO: rd_w = csel_lo_q;
        `LCC_OFS_CSEL_HI: rd_w = {24'h000000, csel_hi_q};
        `LCC_OFS_STATUS:
        begin
          rd_w[NC-1:0] = out_q;
          rd_w[`LCC_STAT_REG_LSB +: NC] = reg_w;
          rd_w[`LCC_STAT_CARRY] = carry_q;
        end
        default: rd_w = `LCC_RST_WORD;
      endcase
    end
  end

  // one wait cycle per access, then the answer for one cycle
  always_comb
  begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if ((avs_read_i | avs_write_i) && wait_q)
    begin
      wait_d = 1'b0;
      if (avs_read_i)
      begin
        rdata_d = rd_w;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      wait_q  <= 1'b1;
      rdata_q <= `LCC_RST_WORD;
    end
    else
    begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // register writes land on the edge that ends the answer cycle, one edge after the wait ends
  always_comb
  begin
    csel_lo_d = csel_lo_q;
    csel_hi_d = csel_hi_q;
    for (int n = 0; n < NC; n++)
    begin
      mask_d[n] = mask_q[n];
      cfg_d[n]  = cfg_q[n];
    end
    if (commit_w)
    begin
      if (page_w == `LCC_PAGE_MASK && idx_ok_w)
      begin
        mask_d[idx_w] = 16'(merge_be({16'h0000, mask_q[idx_w]},
                                     avs_writedata_i, avs_byteenable_i));
      end
      else if (page_w == `LCC_PAGE_CFG && idx_ok_w)
      begin
        cfg_d[idx_w] = merge_be(cfg_q[idx_w], avs_writedata_i,
                                avs_byteenable_i) & `LCC_CFG_WMASK;
      end
      else if (avs_address_i == `LCC_OFS_CSEL_LO)
      begin
        csel_lo_d = merge_be(csel_lo_q, avs_writedata_i, avs_byteenable_i);
      end
      else if (avs_address_i == `LCC_OFS_CSEL_HI && avs_byteenable_i[0])
      begin
        csel_hi_d = avs_writedata_i[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      csel_lo_q <= `LCC_RST_WORD;
      csel_hi_q <= `LCC_RST_HI;
      for (int n = 0; n < NC; n++)
      begin
        mask_q[n] <= `LCC_RST_MASK;
        cfg_q[n]  <= `LCC_RST_WORD;
      end
    end
    else
    begin
      csel_lo_q <= csel_lo_d;
      csel_hi_q <= csel_hi_d;
      for (int n = 0; n < NC; n++)
      begin
        mask_q[n] <= mask_d[n];
        cfg_q[n]  <= cfg_d[n];
      end
    end
  end

  // cluster outputs registered toward the neighbours
  always_comb
  begin
    carry_d = cout_w[NC-1];
    chain_d = reg_w[NC-1];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      out_q   <= '0;
      carry_q <= 1'b0;
      chain_q <= 1'b0;
    end
    else
    begin
      out_q   <= out_d;
      carry_q <= carry_d;
      chain_q <= chain_d;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign cell_out_o        = out_q;
  assign carry_out_o       = carry_q;
  assign reg_chain_out_o   = chain_q;

endmodule // lcc_logic_cluster

// File: bench/lcc_logic_cluster_asserts.sv
`timescale 1ns/1ps
module lcc_logic_cluster_asserts
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  input  wire logic [9:0]  cell_out_o,
  input  wire logic        carry_out_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic req;
  logic rd_ok;
  logic spare;
  logic taken;
  assign req   = avs_read_i | avs_write_i;
  assign taken = req & avs_waitrequest_o;
  assign rd_ok = avs_read_i & ~avs_waitrequest_o;
  // only aligned holes count; unaligned decode is left open
  assign spare = avs_address_i[1:0] == 2'h0 &&
                 !(avs_address_i inside {8'h00, 8'h04, 8'h08}) &&
                 !(avs_address_i inside {[8'h40:8'h64]}) &&
                 !(avs_address_i inside {[8'h80:8'ha4]});
  sequence s_taken;
    req && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  a_wait_one_cycle: assert property (s_taken |=> s_answer)
    else $error("bus answer not after exactly one wait cycle");
  a_idle_wait_high: assert property (!req |-> avs_waitrequest_o)
    else $error("waitrequest low without a request");
  a_fall_has_cause: assert property
    ($fell(avs_waitrequest_o) |-> $past(taken))
    else $error("waitrequest fell without a taken request");
  a_hole_reads_zero: assert property (rd_ok && spare |-> avs_readdata_o == 0)
    else $error("unmapped read not zero");
  a_cfg_spare_zero: assert property (rd_ok &&
    avs_address_i inside {[8'h80:8'ha4]} |-> avs_readdata_o[31:30] == 2'h0)
    else $error("cell config spare bits not zero");
  a_mask_spare_zero: assert property (rd_ok &&
    avs_address_i inside {[8'h40:8'h64]} |-> avs_readdata_o[31:16] == 0)
    else $error("lookup mask upper half not zero");
  a_status_mirror: assert property (rd_ok && avs_address_i == 8'h08 |->
    avs_readdata_o[9:0] == $past(cell_out_o) &&
    avs_readdata_o[28] == $past(carry_out_o))
    else $error("status does not mirror cell outputs");
  a_data_holds: assert property ($changed(avs_readdata_o) |-> rd_ok)
    else $error("read data changed outside a read answer");
endmodule // lcc_logic_cluster_asserts

// File: bench/lcc_fab_model.sv
`timescale 1ns/1ps
module lcc_fab_model
(
  input  wire logic       ref_clk_i,
  input  wire logic [1:0] pulse_i,
  output logic      [7:0] row_clk_o
);
  logic [7:0] row_d;
  logic [7:0] row_q = 8'h00;
  // row lines idle low between pulses; upper lines stand still
  always_comb row_d = {6'h00, pulse_i};
  always @(posedge ref_clk_i) row_q <= row_d;
  assign row_clk_o = row_q;
endmodule // lcc_fab_model

// File: bench/test_lcc_logic_cluster.sv
`timescale 1ns/1ps
module test_lcc_logic_cluster;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [7:0]  row_clk_i;
  logic [7:0]  route_i = 8'h00;
  logic [9:0]  direct_left_i = 10'h000;
  logic [9:0]  direct_right_i = 10'h000;
  logic        carry_in_i = 1'b0;
  logic        reg_chain_in_i = 1'b0;
  logic [1:0]  pulse = 2'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [9:0]  cell_out_o;
  logic        carry_out_o;
  logic        reg_chain_out_o;
  logic [63:0] notes[$];
  logic [63:0] nt;
  logic [15:0] m[10];
  logic [9:0]  l;
  logic [9:0]  a;
  logic [9:0]  b;
  logic [9:0]  e;
  logic [10:0] s;
  logic        sub;
  int          miscompares = 0;
  int          n_compared = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  lcc_logic_cluster uut (.ref_clk_i, .reset_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .row_clk_i, .route_i, .direct_left_i,
    .direct_right_i, .carry_in_i, .reg_chain_in_i, .cell_out_o,
    .carry_out_o, .reg_chain_out_o);
  lcc_fab_model fab (.ref_clk_i, .pulse_i(pulse), .row_clk_o(row_clk_i));

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check_word(input string nm, input logic [31:0] ex,
                            input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
  endtask

  always @(posedge ref_clk_i)
    if (avs_read_i && avs_waitrequest_o === 1'b0)
    begin
      nt = notes.pop_front();
      check_word("readdata", nt[31:0], avs_readdata_o & nt[63:32]);
    end

  // x is the byte enable for a write and the compare mask for a read
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, input logic [31:0] x);
    int n;
    n = 0;
    if (!w)
      notes.push_back({x, d & x});
    avs_address_i <= ad;
    avs_writedata_i <= d;
    avs_byteenable_i <= x[3:0];
    avs_write_i <= w;
    avs_read_i <= !w;
    // waitrequest is seen on the rising edge, before it updates
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0)
    begin
      miscompares++;
      $display("unexpected wait: expected answer, seen none");
      wrap_up();
    end
    else
    begin
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge ref_clk_i);
    end
  endtask

  task automatic st(input logic [9:0] ex);
    bus(1'b0, 8'h08, {6'h0, ex, 6'h0, ex}, 32'h03ff03ff);
  endtask

  task automatic tick(input int k);
    pulse[k] <= 1'b1;
    @(posedge ref_clk_i);
    pulse[k] <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask

  task automatic apply(input logic [7:0] v, input logic [1:0] t,
                       input logic [9:0] ex);
    route_i <= v;
    @(posedge ref_clk_i);
    if (t[0])
      tick(0);
    if (t[1])
      tick(1);
    repeat (3) @(posedge ref_clk_i);
    st(ex);
  endtask

  function automatic logic [5:0] sl(input int d, input int i);
    return d < 0 ? 6'h3f : 6'(d + i);
  endfunction

  // d2 is absolute, the other selects step with the cell index
  task automatic set_cells(input logic [31:0] base, input logic [31:0] hi,
    input int d0, input int d1, input int d2, input int d3,
    input logic [15:0] mk, input logic rnd);
    logic [31:0] c;
    for (int i = 0; i < 10; i++)
    begin
      m[i] = rnd ? 16'($urandom) : mk;
      c = base | (i > 4 ? hi : 32'h0) |
          {8'h0, sl(d3, i), sl(d2, 0), sl(d1, i), sl(d0, i)};
      bus(1'b1, 8'(8'h40 + 4 * i), 32'(m[i]), 32'hf);
      bus(1'b1, 8'(8'h80 + 4 * i), c, 32'hf);
    end
  endtask

  initial
  begin
    void'($urandom(30));
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    foreach (m[i])
      bus(1'b0, 8'(8'h40 + 4 * i), 32'h0, 32'hffffffff);
    bus(1'b0, 8'h00, 32'h0, 32'hffffffff);
    bus(1'b0, 8'h04, 32'h0, 32'hffffffff);
    bus(1'b1, 8'h0c, 32'hffffffff, 32'hf);
    bus(1'b0, 8'h0c, 32'h0, 32'hffffffff);
    bus(1'b1, 8'h00, 32'h12345678, 32'h5);
    bus(1'b0, 8'h00, 32'h00340078, 32'hffffffff);
    bus(1'b1, 8'h04, 32'h0000ffff, 32'h2);
    bus(1'b0, 8'h04, 32'h0, 32'hffffffff);
    st(10'h000);
    $display("test reset and access done");
    set_cells(32'h0, 32'h0, 18, 28, 0, -1, 16'h0, 1'b1);
    repeat (4)
    begin
      route_i <= 8'($urandom);
      direct_left_i <= 10'($urandom);
      direct_right_i <= 10'($urandom);
      repeat (3) @(posedge ref_clk_i);
      foreach (m[i])
        e[i] = m[i][{1'b0, route_i[0], direct_right_i[i], direct_left_i[i]}];
      bus(1'b0, 8'h08, {22'h0, e}, 32'h3ff);
    end
    $display("test lookup routing done");
    // quiet routing first, else new selects may clear or load registers
    route_i <= 8'h00;
    bus(1'b1, 8'h00, 32'hdcba9810, 32'hf);
    bus(1'b1, 8'h04, 32'h000000fe, 32'hf);
    set_cells(32'h01000000, 32'h06000000, 18, -1, -1, 28, 16'haaaa, 1'b0);
    l = 10'($urandom);
    direct_left_i <= l;
    route_i <= 8'h00;
    @(posedge ref_clk_i);
    apply(8'h03, 2'b01, {5'h0, l[4:0]});
    apply(8'h03, 2'b10, l);
    direct_left_i <= ~l;
    apply(8'h00, 2'b11, l);
    apply(8'h13, 2'b11, 10'h0);
    apply(8'h03, 2'b11, ~l);
    apply(8'h53, 2'b11, 10'h0);
    apply(8'h03, 2'b11, ~l);
    apply(8'h04, 2'b00, {~l[9:5], 5'h0});
    direct_right_i <= 10'h3ff;
    apply(8'h20, 2'b00, 10'h3ff);
    apply(8'h28, 2'b00, 10'h01f);
    $display("test cluster controls done");
    set_cells(32'h11000000, 32'h0, -1, -1, -1, -1, 16'h0, 1'b0);
    route_i <= 8'h03;
    e = 10'h3ff;
    repeat (10)
    begin
      reg_chain_in_i <= 1'($urandom);
      @(posedge ref_clk_i);
      e = {e[8:0], reg_chain_in_i};
      tick(0);
    end
    st(e);
    check_word("chain_out", {31'h0, e[9]}, {31'h0, reg_chain_out_o});
    $display("test register chain done");
    set_cells(32'h20000000, 32'h0, 18, 28, -1, -1, 16'h0, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      a = 10'($urandom);
      b = 10'($urandom);
      sub = k[0];
      route_i <= {sub, 7'h0};
      direct_left_i <= a;
      direct_right_i <= b;
      carry_in_i <= 1'($urandom);
      repeat (3) @(posedge ref_clk_i);
      s = {1'b0, a} + (sub ? {1'b0, ~b} + 11'h1 : {1'b0, b} + carry_in_i);
      bus(1'b0, 8'h08, {3'h0, s[10], 18'h0, s[9:0]}, 32'h100003ff);
    end
    $display("test add and subtract done");
    set_cells(32'h08000000, 32'h0, -1, 18, -1, -1, 16'h6666, 1'b0);
    l = 10'($urandom);
    direct_left_i <= l;
    repeat (3) @(posedge ref_clk_i);
    e[0] = l[0];
    for (int i = 1; i < 10; i++)
      e[i] = e[i - 1] ^ l[i];
    bus(1'b0, 8'h08, {22'h0, e}, 32'h3ff);
    $display("test lookup chain done");
    wrap_up();
  end
endmodule // test_lcc_logic_cluster

bind lcc_logic_cluster lcc_logic_cluster_asserts chk (.ref_clk_i,
  .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .cell_out_o, .carry_out_o);
